/* logic/dvr_pkg.sv */
/*
  Constants, register map and state encodings for the verify/recalibrate/
  unlock command block. Assumes a single 10 MHz AHB-Lite clock domain.
*/
package dvr_pkg;
  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] DVR_OFS_DATA = 8'h00;
  localparam logic [7:0] DVR_OFS_ERR = 8'h04;
  localparam logic [7:0] DVR_OFS_SCNT = 8'h08;
  localparam logic [7:0] DVR_OFS_SNUM = 8'h0c;
  localparam logic [7:0] DVR_OFS_CYLL = 8'h10;
  localparam logic [7:0] DVR_OFS_CYLH = 8'h14;
  localparam logic [7:0] DVR_OFS_DEVH = 8'h18;
  localparam logic [7:0] DVR_OFS_CMD = 8'h1c;
  localparam logic [7:0] DVR_OFS_SEC = 8'h20;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int DVR_ERR_UNC = 6;
  localparam int DVR_ERR_IDN = 4;
  localparam int DVR_ERR_ABT = 2;
  localparam int DVR_ERR_T0 = 1;
  localparam int DVR_DEVH_LBA = 6;
  localparam int DVR_DEVH_DEV = 4;
  localparam int DVR_PW_ID_BIT = 0;

  // ----------------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------------
  localparam logic [6:0] DVR_OP_VERIFY = 7'h20;
  localparam logic [3:0] DVR_OP_RECAL = 4'h1;
  localparam logic [7:0] DVR_OP_DIS_PW = 8'hf6;

  // ----------------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------------
  localparam logic [8:0] DVR_FULL_RUN = 9'h100;
  localparam logic [8:0] DVR_SCNT_RST = 9'h001;
  localparam logic [7:0] DVR_SNUM_RST = 8'h01;
  localparam logic [7:0] DVR_ERR_RST = 8'h00;
  localparam logic DVR_LOCK_RST = 1'b0;
  localparam logic [7:0] DVR_SECT_PER_TRK = 8'h3f;
  localparam logic [3:0] DVR_LAST_HEAD = 4'hf;
  localparam logic [8:0] DVR_SECTOR_WORDS = 9'h100;
  localparam logic [8:0] DVR_PW_WORDS = 9'h010;

  typedef enum logic [2:0] {
    DVR_IDLE = 3'b000,
    DVR_VERIFY = 3'b001,
    DVR_SEEK = 3'b010,
    DVR_PW_XFER = 3'b011,
    DVR_PW_CHECK = 3'b100
  } dvr_state_e;
endpackage : dvr_pkg

/* logic/dvr_pw_check.sv */
/*
  Password sector receiver and comparator. Assumes words arrive one per
  valid pulse on the same clock, control word first.
*/
`timescale 1ns/1ps
module dvr_pw_check
  import dvr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic word_valid,
  input wire logic [15:0] word,
  input wire logic [255:0] user_pw,
  input wire logic [255:0] master_pw,
  output logic done,
  output logic match
);
  import dvr_pkg::*;

  typedef struct packed {
    logic [8:0] idx;
    logic ident;
    logic mismatch;
    logic done;
  } dvr_pw_s;

  dvr_pw_s s;
  dvr_pw_s next_s;
  logic [255:0] sel_pw;
  logic [3:0] slot;

  assign sel_pw = s.ident ? master_pw : user_pw;
  assign slot = 4'(s.idx[4:0] - 5'd1);

  always_comb begin
    next_s = s;
    if (start) begin
      next_s = '0;
    end else if (word_valid && !s.done) begin
      // Words past the password are read and dropped; they only count
      if (s.idx == 9'h000) begin
        next_s.ident = word[DVR_PW_ID_BIT];
      end else if (s.idx <= DVR_PW_WORDS) begin
        if (word != sel_pw[{slot, 4'h0} +: 16]) begin
          next_s.mismatch = 1'b1;
        end
      end
      next_s.idx = s.idx + 9'd1;
      if (s.idx == DVR_SECTOR_WORDS - 9'd1) begin
        next_s.done = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done = s.done;
  assign match = ~s.mismatch;
endmodule : dvr_pw_check

/* logic/dvr_cmd_core.sv */
/*
  Task-file command core: read-verify, recalibrate and disable-password,
  reached over an AHB-Lite slave. Assumes the media controller and the
  password store run on hclk, so their signals need no synchroniser.
*/
`timescale 1ns/1ps
module dvr_cmd_core
  import dvr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic verify_req,
  output logic [27:0] media_addr,
  output logic media_lba_mode,
  output logic media_no_retry,
  input wire logic verify_done,
  input wire logic verify_uncorrectable,
  input wire logic verify_id_missing,
  output logic seek_req,
  input wire logic seek_done,
  input wire logic seek_track_zero_fail,
  input wire logic [255:0] user_pw,
  input wire logic [255:0] master_pw,
  output logic locked
);
  import dvr_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    dvr_state_e st;
    logic [8:0] remain;
    logic [7:0] sect;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [3:0] head;
    logic lba_mode;
    logic dev_sel;
    logic no_retry;
    logic [7:0] err;
    logic bsy;
    logic drq;
    logic errb;
    logic locked;
    logic verify_req;
    logic seek_req;
    logic pw_start;
    logic pw_valid;
    logic [15:0] pw_word;
    logic ph_act;
    logic ph_wr;
    logic [7:0] ph_addr;
    logic [31:0] rdata;
  } dvr_core_s;

  dvr_core_s s;
  dvr_core_s next_s;
  logic pw_done;
  logic pw_match;
  logic addr_take;
  logic [7:0] status;
  logic [27:0] lba;
  logic [27:0] lba_next;
  logic [7:0] cmd;

  function automatic logic dvr_hit(input logic [7:0] a, input logic [7:0] ofs);
    dvr_hit = (a == ofs);
  endfunction : dvr_hit

  // Low nibble of the recalibrate family is a don't-care, so only the top is decoded
  function automatic logic dvr_is_verify(input logic [7:0] op);
    dvr_is_verify = (op[7:1] == DVR_OP_VERIFY);
  endfunction : dvr_is_verify

  function automatic logic dvr_is_recal(input logic [7:0] op);
    dvr_is_recal = (op[7:4] == DVR_OP_RECAL);
  endfunction : dvr_is_recal

  function automatic logic dvr_is_dis_pw(input logic [7:0] op);
    dvr_is_dis_pw = (op == DVR_OP_DIS_PW);
  endfunction : dvr_is_dis_pw

  // ----------------------------------------------------------------------
  // Password sector receiver
  // ----------------------------------------------------------------------
  dvr_pw_check u_pw (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(s.pw_start),
    .word_valid(s.pw_valid),
    .word(s.pw_word),
    .user_pw(user_pw),
    .master_pw(master_pw),
    .done(pw_done),
    .match(pw_match)
  );

  // ----------------------------------------------------------------------
  // Bus and address helpers
  // ----------------------------------------------------------------------
  assign addr_take = hsel && htrans[1] && hready;
  // Zero wait states: every transfer finishes in its first data cycle
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // Ready and seek-complete stay set: this block has no spin-down or fault state
  assign status = {
    s.bsy,
    1'b1,
    1'b0,
    1'b1,
    s.drq,
    1'b0,
    1'b0,
    s.errb
  };
  assign lba = {s.head, s.cyl_hi, s.cyl_lo, s.sect};
  assign lba_next = lba + 28'd1;
  assign cmd = hwdata[7:0];

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.verify_req = 1'b0;
    next_s.seek_req = 1'b0;
    next_s.pw_start = 1'b0;
    next_s.pw_valid = 1'b0;

    // Data phase of a write; task file is frozen while busy or requesting
    if (s.ph_act && s.ph_wr) begin
      if (dvr_hit(s.ph_addr, DVR_OFS_DATA)) begin
        if (s.st == DVR_PW_XFER && s.drq) begin
          next_s.pw_valid = 1'b1;
          next_s.pw_word = hwdata[15:0];
        end
      end else if (!s.bsy && !s.drq) begin
        if (dvr_hit(s.ph_addr, DVR_OFS_SCNT)) begin
          next_s.remain = (cmd == 8'h00) ? DVR_FULL_RUN : {1'b0, cmd};
        end else if (dvr_hit(s.ph_addr, DVR_OFS_SNUM)) begin
          next_s.sect = cmd;
        end else if (dvr_hit(s.ph_addr, DVR_OFS_CYLL)) begin
          next_s.cyl_lo = cmd;
        end else if (dvr_hit(s.ph_addr, DVR_OFS_CYLH)) begin
          next_s.cyl_hi = cmd;
        end else if (dvr_hit(s.ph_addr, DVR_OFS_DEVH)) begin
          next_s.head = cmd[3:0];
          next_s.lba_mode = cmd[DVR_DEVH_LBA];
          next_s.dev_sel = cmd[DVR_DEVH_DEV];
        end else if (dvr_hit(s.ph_addr, DVR_OFS_SEC)) begin
          // Arming the lock stands in for setting a user password
          if (cmd[0]) begin
            next_s.locked = 1'b1;
          end
        end else if (dvr_hit(s.ph_addr, DVR_OFS_CMD) && s.st == DVR_IDLE) begin
          next_s.err = DVR_ERR_RST;
          next_s.errb = 1'b0;
          if (dvr_is_verify(cmd)) begin
            next_s.bsy = 1'b1;
            next_s.no_retry = cmd[0];
            next_s.verify_req = 1'b1;
            next_s.st = DVR_VERIFY;
          end else if (dvr_is_recal(cmd)) begin
            next_s.bsy = 1'b1;
            next_s.seek_req = 1'b1;
            next_s.st = DVR_SEEK;
          end else if (dvr_is_dis_pw(cmd)) begin
            next_s.drq = 1'b1;
            next_s.pw_start = 1'b1;
            next_s.st = DVR_PW_XFER;
          end else begin
            next_s.err[DVR_ERR_ABT] = 1'b1;
            next_s.errb = 1'b1;
          end
        end
      end
    end

    // Command sequencing
    case (s.st)
      DVR_IDLE: begin
      end
      DVR_VERIFY: begin
        // No data request is raised: sectors are checked, never sent
        if (verify_done) begin
          if (verify_uncorrectable || verify_id_missing) begin
            // Count and address are left on the failing sector
            next_s.err[DVR_ERR_UNC] = verify_uncorrectable;
            next_s.err[DVR_ERR_IDN] = verify_id_missing;
            next_s.errb = 1'b1;
            next_s.bsy = 1'b0;
            next_s.st = DVR_IDLE;
          end else if (s.remain == 9'd1) begin
            next_s.remain = 9'd0;
            next_s.bsy = 1'b0;
            next_s.st = DVR_IDLE;
          end else begin
            next_s.remain = s.remain - 9'd1;
            next_s.verify_req = 1'b1;
            if (s.lba_mode) begin
              next_s.sect = lba_next[7:0];
              next_s.cyl_lo = lba_next[15:8];
              next_s.cyl_hi = lba_next[23:16];
              next_s.head = lba_next[27:24];
            end else if (s.sect < DVR_SECT_PER_TRK) begin
              next_s.sect = s.sect + 8'd1;
            end else begin
              next_s.sect = DVR_SNUM_RST;
              if (s.head < DVR_LAST_HEAD) begin
                next_s.head = s.head + 4'd1;
              end else begin
                next_s.head = 4'h0;
                {next_s.cyl_hi, next_s.cyl_lo} = {s.cyl_hi, s.cyl_lo} + 16'd1;
              end
            end
          end
        end
      end
      DVR_SEEK: begin
        if (seek_done) begin
          if (seek_track_zero_fail) begin
            next_s.err[DVR_ERR_T0] = 1'b1;
            next_s.errb = 1'b1;
          end
          next_s.bsy = 1'b0;
          next_s.st = DVR_IDLE;
        end
      end
      DVR_PW_XFER: begin
        // Check waits until the whole sector has been written
        if (pw_done && !s.pw_start) begin
          next_s.drq = 1'b0;
          next_s.bsy = 1'b1;
          next_s.st = DVR_PW_CHECK;
        end
      end
      DVR_PW_CHECK: begin
        // Stored passwords are only compared, never written, so the master survives
        if (pw_match) begin
          next_s.locked = 1'b0;
        end else begin
          next_s.err[DVR_ERR_ABT] = 1'b1;
          next_s.errb = 1'b1;
        end
        next_s.bsy = 1'b0;
        next_s.st = DVR_IDLE;
      end
      default: begin
        next_s.st = DVR_IDLE;
        next_s.bsy = 1'b0;
        next_s.drq = 1'b0;
      end
    endcase

    // Address phase: capture read data now so hrdata comes from a flop
    next_s.ph_act = addr_take;
    next_s.ph_wr = addr_take && hwrite;
    next_s.ph_addr = haddr[7:0];
    if (addr_take && !hwrite) begin
      next_s.rdata = 32'h0000_0000;
      if (haddr[31:8] == 24'h00_0000) begin
        if (dvr_hit(haddr[7:0], DVR_OFS_ERR)) begin
          next_s.rdata[7:0] = s.err;
        end else if (dvr_hit(haddr[7:0], DVR_OFS_SCNT)) begin
          next_s.rdata[7:0] = s.remain[7:0];
        end else if (dvr_hit(haddr[7:0], DVR_OFS_SNUM)) begin
          next_s.rdata[7:0] = s.sect;
        end else if (dvr_hit(haddr[7:0], DVR_OFS_CYLL)) begin
          next_s.rdata[7:0] = s.cyl_lo;
        end else if (dvr_hit(haddr[7:0], DVR_OFS_CYLH)) begin
          next_s.rdata[7:0] = s.cyl_hi;
        end else if (dvr_hit(haddr[7:0], DVR_OFS_DEVH)) begin
          next_s.rdata[7:0] = {1'b1, s.lba_mode, 1'b1, s.dev_sel, s.head};
        end else if (dvr_hit(haddr[7:0], DVR_OFS_CMD)) begin
          next_s.rdata[7:0] = status;
        end else if (dvr_hit(haddr[7:0], DVR_OFS_SEC)) begin
          next_s.rdata[0] = s.locked;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.st <= DVR_IDLE;
      s.sect <= DVR_SNUM_RST;
      s.remain <= DVR_SCNT_RST;
      s.err <= DVR_ERR_RST;
      s.locked <= DVR_LOCK_RST;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign hrdata = s.rdata;
  assign verify_req = s.verify_req;
  assign media_addr = lba;
  assign media_lba_mode = s.lba_mode;
  assign media_no_retry = s.no_retry;
  assign seek_req = s.seek_req;
  assign locked = s.locked;
endmodule : dvr_cmd_core

/* verification/dvr_cmd_core_assertions.sv */
/*
  Port checker for the command core, bound to dvr_cmd_core.
  Assumes one hclk domain and the media answering on that clock.
*/
`timescale 1ns/1ps
module dvr_cmd_core_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic verify_req,
  input wire logic [27:0] media_addr,
  input wire logic media_lba_mode,
  input wire logic media_no_retry,
  input wire logic verify_done,
  input wire logic verify_uncorrectable,
  input wire logic verify_id_missing,
  input wire logic seek_req,
  input wire logic seek_done
);
  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence good_s;
    verify_done && !verify_uncorrectable && !verify_id_missing;
  endsequence
  sequence bad_s;
    verify_done && (verify_uncorrectable || verify_id_missing);
  endsequence
  zero_wait_a: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  vreq_pulse_a: assert property (verify_req |=> !verify_req)
    else $error("verify request longer than one cycle");
  sreq_pulse_a: assert property (seek_req |=> !seek_req)
    else $error("seek request longer than one cycle");
  req_excl_a: assert property (!(verify_req && seek_req))
    else $error("seek and verify requested together");
  lba_step_a: assert property (good_s ##1 (verify_req && media_lba_mode)
    |-> media_addr == $past(media_addr) + 28'h1)
    else $error("next sector address not one above the last");
  err_stop_a: assert property (bad_s |=> !verify_req [*3])
    else $error("verify went on after a failing sector");
  seek_quiet_a: assert property (seek_done |=> !seek_req [*2])
    else $error("seek requested again after completion");
  mode_hold_a: assert property (verify_req |=> $stable(media_no_retry)
    && $stable(media_lba_mode) && $stable(media_addr))
    else $error("sector mode or address moved during a verify");
endmodule : dvr_cmd_core_checker

bind dvr_cmd_core dvr_cmd_core_checker u_chk (.hclk, .hresetn, .hreadyout, .hresp,
  .verify_req, .media_addr, .media_lba_mode, .media_no_retry, .verify_done,
  .verify_uncorrectable, .verify_id_missing, .seek_req, .seek_done);

/* verification/dvr_media_model.sv */
/*
  Media and actuator model answering sector verify and seek requests.
  Assumes one-cycle request pulses on hclk; bench sets the faults.
*/
`timescale 1ns/1ps
module dvr_media_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic verify_req,
  input wire logic [27:0] media_addr,
  input wire logic seek_req,
  input wire logic slow,
  input wire logic bad_en,
  input wire logic [27:0] bad_addr,
  input wire logic seek_fail,
  input wire logic idn_en,
  output logic verify_done,
  output logic verify_uncorrectable,
  output logic verify_id_missing,
  output logic seek_done,
  output logic seek_track_zero_fail
);
  // --------------------------------------------------------------------
  // Responder
  // --------------------------------------------------------------------
  logic [3:0] cnt;
  logic vbusy;
  logic sbusy;
  logic tog;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 4'h0;
      vbusy <= 1'b0;
      sbusy <= 1'b0;
      tog <= 1'b0;
      verify_done <= 1'b0;
      seek_done <= 1'b0;
      verify_uncorrectable <= 1'b0;
      verify_id_missing <= 1'b0;
      seek_track_zero_fail <= 1'b0;
    end else begin
      tog <= ~tog;
      verify_done <= 1'b0;
      seek_done <= 1'b0;
      // Flags toggle outside a result so a stale value is never trusted
      verify_uncorrectable <= tog;
      verify_id_missing <= ~tog;
      seek_track_zero_fail <= tog;
      if (verify_req || seek_req) begin
        cnt <= slow ? 4'h6 : 4'h1;
        vbusy <= verify_req;
        sbusy <= seek_req;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
        if (cnt == 4'h1) begin
          verify_done <= vbusy;
          seek_done <= sbusy;
          verify_uncorrectable <= bad_en && !idn_en && (media_addr == bad_addr);
          verify_id_missing <= bad_en && idn_en && (media_addr == bad_addr);
          seek_track_zero_fail <= seek_fail;
        end
      end
    end
  end
endmodule : dvr_media_model

/* verification/disk_verify_recal_unlock_cmds_bench.sv */
/*
  Self-checking bench for the command core: AHB-Lite host tasks,
  media model on the far side. Assumes hready fed from hreadyout.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module disk_verify_recal_unlock_cmds_bench;
  import dvr_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, verify_req, media_lba_mode;
  logic media_no_retry, verify_done, verify_uncorrectable, verify_id_missing;
  logic seek_req, seek_done, seek_track_zero_fail, locked, slow, bad_en, seek_fail, idn_en;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [27:0] media_addr, bad_addr;
  logic [255:0] user_pw, master_pw;
  int errors, comparisons, vreqs, sreqs;
  dvr_cmd_core u_dvr_cmd_core (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .verify_req, .media_addr,
    .media_lba_mode, .media_no_retry, .verify_done, .verify_uncorrectable,
    .verify_id_missing, .seek_req, .seek_done, .seek_track_zero_fail, .user_pw,
    .master_pw, .locked);
  dvr_media_model u_dvr_media_model (.hclk, .hresetn, .verify_req, .media_addr, .seek_req,
    .slow, .bad_en, .bad_addr, .seek_fail, .idn_en, .verify_done, .verify_uncorrectable,
    .verify_id_missing, .seek_done, .seek_track_zero_fail);
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (verify_req === 1'b1) vreqs++;
    if (seek_req === 1'b1) sreqs++;
  end
  // --------------------------------------------------------------------
  // Bus tasks
  // --------------------------------------------------------------------
  task automatic give_verdict();
    if (errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic stuck();
    errors++;
    $display("[ERR] wait exp done got timeout");
    give_verdict();
  endtask : stuck
  task automatic rdy();
    int n;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) stuck();
  endtask : rdy
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
    r = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] r;
    bus(a, 1'b1, {16'h0, d}, r);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    `CHK($sformatf("reg %h", a), e, r[7:0])
  endtask : rd_chk
  task automatic poll(input logic [7:0] m, input logic [7:0] v);
    logic [31:0] r;
    int n;
    n = 0;
    do begin bus(DVR_OFS_CMD, 1'b0, 32'h0, r); n++; end while ((r[7:0] & m) !== v && n < 3000);
    if ((r[7:0] & m) !== v) stuck();
  endtask : poll
  task automatic verify_run(input logic [7:0] op, dh, sn, cl, ch, cnt);
    wr(DVR_OFS_DEVH, {8'h0, dh});
    wr(DVR_OFS_SNUM, {8'h0, sn});
    wr(DVR_OFS_CYLL, {8'h0, cl});
    wr(DVR_OFS_CYLH, {8'h0, ch});
    wr(DVR_OFS_SCNT, {8'h0, cnt});
    vreqs = 0;
    wr(DVR_OFS_CMD, {8'h0, op});
    poll(8'h88, 8'h00);
  endtask : verify_run
  task automatic pw_send(input logic id, input logic [255:0] pw, input logic lk);
    logic [31:0] r;
    wr(DVR_OFS_CMD, 16'hf6);
    poll(8'h08, 8'h08);
    wr(DVR_OFS_DATA, {15'h0, id});
    for (int k = 0; k < 16; k++) wr(DVR_OFS_DATA, pw[16*k +: 16]);
    for (int k = 17; k < 255; k++) wr(DVR_OFS_DATA, 16'hffff);
    bus(DVR_OFS_CMD, 1'b0, 32'h0, r);
    `CHK("drq before last word", 1'b1, r[3])
    `CHK("lock before last word", lk, locked)
    wr(DVR_OFS_DATA, 16'hffff);
    poll(8'h88, 8'h00);
  endtask : pw_send
  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_idle();
    rd_chk(DVR_OFS_CMD, 8'h50);
    rd_chk(DVR_OFS_SCNT, 8'h01);
    wr(DVR_OFS_ERR, 16'h00ff);
    rd_chk(DVR_OFS_ERR, 8'h00);
    rd_chk(8'h40, 8'h00);
    wr(DVR_OFS_DATA, 16'h1234);
    wr(DVR_OFS_CMD, 16'h0000);
    rd_chk(DVR_OFS_ERR, 8'h04);
    rd_chk(DVR_OFS_CMD, 8'h51);
  endtask : t_idle
  task automatic t_verify();
    verify_run(8'h41, 8'h45, 8'hef, 8'hcd, 8'hab, 8'h03);
    `CHK("verifies", 3, vreqs)
    `CHK("no retry", 1'b1, media_no_retry)
    `CHK("media addr", 28'h5abcdf1, media_addr)
    rd_chk(DVR_OFS_SCNT, 8'h00);
    rd_chk(DVR_OFS_SNUM, 8'hf1);
    rd_chk(DVR_OFS_CYLL, 8'hcd);
    rd_chk(DVR_OFS_CYLH, 8'hab);
    rd_chk(DVR_OFS_DEVH, 8'he5);
    rd_chk(DVR_OFS_CMD, 8'h50);
    slow <= 1'b1;
    bad_en <= 1'b1;
    bad_addr <= 28'h0000012;
    verify_run(8'h40, 8'h40, 8'h10, 8'h00, 8'h00, 8'h05);
    `CHK("verifies to error", 3, vreqs)
    `CHK("retry allowed", 1'b0, media_no_retry)
    rd_chk(DVR_OFS_SCNT, 8'h03);
    rd_chk(DVR_OFS_SNUM, 8'h12);
    rd_chk(DVR_OFS_ERR, 8'h40);
    rd_chk(DVR_OFS_CMD, 8'h51);
    idn_en <= 1'b1;
    verify_run(8'h40, 8'h40, 8'h10, 8'h00, 8'h00, 8'h05);
    `CHK("verifies to id miss", 3, vreqs)
    rd_chk(DVR_OFS_SCNT, 8'h03);
    rd_chk(DVR_OFS_ERR, 8'h10);
    idn_en <= 1'b0;
    slow <= 1'b0;
    bad_en <= 1'b0;
    verify_run(8'h40, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00);
    `CHK("full run", 256, vreqs)
    rd_chk(DVR_OFS_SNUM, 8'hff);
    verify_run(8'h40, 8'h10, 8'h3f, 8'h00, 8'h00, 8'h02);
    `CHK("chs mode", 1'b0, media_lba_mode)
    `CHK("chs addr", 28'h1000001, media_addr)
    rd_chk(DVR_OFS_DEVH, 8'hb1);
  endtask : t_verify
  task automatic t_recal();
    logic [7:0] ops [3] = '{8'h10, 8'h1f, 8'h17};
    for (int i = 0; i < 3; i++) begin
      seek_fail <= (i == 2);
      sreqs = 0;
      wr(DVR_OFS_CMD, {8'h0, ops[i]});
      poll(8'h88, 8'h00);
      `CHK("seeks", 1, sreqs)
      rd_chk(DVR_OFS_ERR, (i == 2) ? 8'h02 : 8'h00);
      rd_chk(DVR_OFS_CMD, (i == 2) ? 8'h51 : 8'h50);
    end
    seek_fail <= 1'b0;
  endtask : t_recal
  task automatic t_unlock();
    wr(DVR_OFS_SEC, 16'h0001);
    pw_send(1'b0, master_pw, 1'b1);
    `CHK("lock kept", 1'b1, locked)
    rd_chk(DVR_OFS_ERR, 8'h04);
    pw_send(1'b1, master_pw, 1'b1);
    `CHK("master unlock", 1'b0, locked)
    rd_chk(DVR_OFS_CMD, 8'h50);
    wr(DVR_OFS_SEC, 16'h0001);
    pw_send(1'b0, user_pw, 1'b1);
    `CHK("user unlock", 1'b0, locked)
    wr(DVR_OFS_SEC, 16'h0001);
    pw_send(1'b1, master_pw, 1'b1);
    `CHK("master kept", 1'b0, locked)
    pw_send(1'b1, master_pw, 1'b0);
    `CHK("unlocked stays", 1'b0, locked)
    rd_chk(DVR_OFS_ERR, 8'h00);
  endtask : t_unlock
  initial begin
    errors = 0;
    comparisons = 0;
    {hsel, hwrite, htrans, haddr, hwdata, slow, bad_en, bad_addr, seek_fail, idn_en} = '0;
    hsize = 3'b010;
    for (int k = 0; k < 16; k++) user_pw[16*k +: 16] = 16'ha000 + 16'(k);
    for (int k = 0; k < 16; k++) master_pw[16*k +: 16] = 16'hb000 + 16'(k);
    hresetn = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    `CHK("reset lock", 1'b0, locked)
    t_idle();
    t_verify();
    t_recal();
    t_unlock();
    give_verdict();
  end
endmodule : disk_verify_recal_unlock_cmds_bench
